// ### mix_route_pkg.sv
// Register map and field layout of the output mix route bank
package mix_route_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int VOL_W = 7;
   localparam int LEVEL_W = 4;
   localparam int NUM_ROUTE = 7;

   localparam logic [6:0] ADDR_RPGA_TO_RCOM_VOL = 7'h46;
   localparam logic [6:0] ADDR_RDAC_TO_RCOM_VOL = 7'h47;
   localparam logic [6:0] ADDR_RCOM_OUT_LEVEL_CTRL = 7'h48;
   localparam logic [6:0] ADDR_LLINE2_TO_MONO_VOL = 7'h49;
   localparam logic [6:0] ADDR_LPGA_TO_MONO_VOL = 7'h4A;
   localparam logic [6:0] ADDR_LDAC_TO_MONO_VOL = 7'h4B;
   localparam logic [6:0] ADDR_RLINE2_TO_MONO_VOL = 7'h4C;
   localparam logic [6:0] ADDR_RPGA_TO_MONO_VOL = 7'h4D;

   // Route register fields
   localparam int ROUTE_BIT = 7;
   localparam int VOL_LSB = 0;
   localparam logic [7:0] ROUTE_RESET = 8'h00;

   // Level control register fields
   localparam int LEVEL_LSB = 4;
   localparam int UNMUTE_BIT = 3;
   localparam int PD_HIZ_BIT = 2;
   localparam int VOL_BUSY_BIT = 1;
   localparam int POWER_UP_BIT = 0;
   localparam logic [3:0] LEVEL_RESET = 4'h0;
   localparam logic [3:0] LEVEL_MAX = 4'h9;
   localparam logic UNMUTE_RESET = 1'b0;
   localparam logic PD_HIZ_RESET = 1'b1;
   localparam logic POWER_UP_RESET = 1'b0;
   localparam logic VOL_BUSY_RESET = 1'b1;

   // Cycles the gain stage may take to apply a new setting
   localparam int SETTLE_CYCLES = 16;
   localparam int SETTLE_W = 5;
endpackage

// ### route_reg.sv
// One route register: route enable bit and 7-bit volume code
`timescale 1ns/1ps
module route_reg
   import mix_route_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Write port
   input wire logic wr_en,
   input wire logic [DATA_W-1:0] wr_data,
   // Stored value
   output logic [DATA_W-1:0] value
);
   always_ff @(posedge clk)
   begin
      if (reset)
         value <= ROUTE_RESET;
      else if (wr_en)
         value <= wr_data;
   end
endmodule

// ### gain_settle.sv
// Tracks whether a newly programmed gain has been applied
`timescale 1ns/1ps
module gain_settle
   import mix_route_pkg::*;
#(
   parameter int CYCLES = SETTLE_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Any gain change
   input wire logic gain_change,
   // Gain not yet applied
   output logic busy
);
   logic [SETTLE_W-1:0] count;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         count <= SETTLE_W'(CYCLES);
         busy <= VOL_BUSY_RESET;
      end
      else if (gain_change)
      begin
         count <= SETTLE_W'(CYCLES);
         busy <= 1'b1;
      end
      else if (count != '0)
      begin
         count <= count - 1'b1;
         busy <= (count != SETTLE_W'(1));
      end
      else
         busy <= 1'b0;
   end
endmodule

// ### output_mix_route_regs.sv
// Control register bank for the right common headphone driver and mono line output
//
// Behaviour
// [R1] Right amp route bit 7 connects right amp pair to common headphone driver; resets 0.
// [R2] Common headphone route registers hold 7-bit volume in bits 6:0, reset zero.
// [R3] Right DAC route bit 7 connects primary right DAC to common driver; resets 0.
// [R4] Level field bits 7:4 resets 0000; codes 0..9 give 0..9 dB.
// [R5] Software never writes level codes 1010 to 1111.
// [R6] Bit 3 clear mutes, set unmutes the driver; resets to muted.
// [R7] Bit 2 clear weak common mode when down, set high impedance; resets 1.
// [R8] Bit 1 read-only, one while programmed gain unapplied; resets one.
// [R9] Bit 0 read-write power-up control, resets zero.
// [R10] Left line-2 to mono route bit 7; resets 0.
// [R11] Left amp to mono route bit 7; resets 0.
// [R12] Left DAC to mono route bit 7; resets 0.
// [R13] Right line-2 to mono route bit 7; resets 0.
// [R14] Right amp to mono route bit 7; resets 0.
// [R15] Five mono route registers hold 7-bit volume in bits 6:0, reset zero.
// [R16] Volume codes go to the gain stage unchanged.
`timescale 1ns/1ps
module output_mix_route_regs
   import mix_route_pkg::*;
#(
   parameter int SETTLE = SETTLE_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata,
   output logic reg_hit,
   // Right common headphone driver controls
   output logic right_amp_to_rcom,
   output logic [VOL_W-1:0] right_amp_to_rcom_vol,
   output logic right_dac_primary_to_rcom,
   output logic [VOL_W-1:0] right_dac_primary_to_rcom_vol,
   output logic [LEVEL_W-1:0] rcom_level,
   output logic rcom_unmute,
   output logic rcom_pd_hiz,
   output logic rcom_power_up,
   output logic rcom_level_reserved,
   // Mono line output routes, index 0..4: left line2, left amp, left dac, right line2, right amp
   output logic [4:0] mono_route,
   output logic [VOL_W-1:0] mono_vol [0:4]
);
   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ROUTE_ADDR [0:NUM_ROUTE-1] = '{
      ADDR_RPGA_TO_RCOM_VOL, ADDR_RDAC_TO_RCOM_VOL, ADDR_LLINE2_TO_MONO_VOL,
      ADDR_LPGA_TO_MONO_VOL, ADDR_LDAC_TO_MONO_VOL, ADDR_RLINE2_TO_MONO_VOL,
      ADDR_RPGA_TO_MONO_VOL};

   logic [DATA_W-1:0] route_val [0:NUM_ROUTE-1];
   logic [NUM_ROUTE-1:0] route_sel;
   logic level_sel;
   logic [LEVEL_W-1:0] level;
   logic unmute;
   logic pd_hiz;
   logic power_up;
   logic vol_busy;
   logic rcom_gain_change;

   assign level_sel = (reg_addr == ADDR_RCOM_OUT_LEVEL_CTRL);

   // ------------------------------------------------------------
   // Route registers
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_ROUTE; g++)
      begin : g_route
         assign route_sel[g] = (reg_addr == ROUTE_ADDR[g]);
         route_reg u_route (
            .clk(clk),
            .reset(reset),
            .wr_en(reg_wr && route_sel[g]), // [R1] [R2] [R3] [R10] [R11] [R12] [R13] [R14] [R15]
            .wr_data(reg_wdata),
            .value(route_val[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Level control register
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         level <= LEVEL_RESET; // [R4]
         unmute <= UNMUTE_RESET; // [R6]
         pd_hiz <= PD_HIZ_RESET; // [R7]
         power_up <= POWER_UP_RESET; // [R9]
      end
      else if (reg_wr && level_sel)
      begin
         level <= reg_wdata[LEVEL_LSB +: LEVEL_W]; // [R4]
         unmute <= reg_wdata[UNMUTE_BIT]; // [R6]
         pd_hiz <= reg_wdata[PD_HIZ_BIT]; // [R7]
         power_up <= reg_wdata[POWER_UP_BIT]; // [R9]
      end
   end

   // ------------------------------------------------------------
   // Volume status of the common headphone driver
   // ------------------------------------------------------------
   // Gain writes to the driver's route or level registers restart settling
   assign rcom_gain_change = reg_wr && (route_sel[0] || route_sel[1] || level_sel);

   gain_settle #(
      .CYCLES(SETTLE)
   ) u_settle (
      .clk(clk),
      .reset(reset),
      .gain_change(rcom_gain_change), // [R8]
      .busy(vol_busy)
   );

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   logic [DATA_W-1:0] next_rdata;
   logic next_hit;

   always_comb
   begin
      next_rdata = '0;
      next_hit = level_sel;
      for (int i = 0; i < NUM_ROUTE; i++)
      begin
         if (route_sel[i])
         begin
            next_rdata = route_val[i];
            next_hit = 1'b1;
         end
      end
      if (level_sel)
         next_rdata = {level, unmute, pd_hiz, vol_busy, power_up}; // [R8]
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         reg_rdata <= '0;
         reg_hit <= 1'b0;
      end
      else if (reg_rd)
      begin
         reg_rdata <= next_rdata;
         reg_hit <= next_hit;
      end
      else
         reg_hit <= 1'b0;
   end

   // ------------------------------------------------------------
   // Registered outputs to the analog stages
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         right_amp_to_rcom <= 1'b0;
         right_amp_to_rcom_vol <= '0;
         right_dac_primary_to_rcom <= 1'b0;
         right_dac_primary_to_rcom_vol <= '0;
         rcom_level <= LEVEL_RESET;
         rcom_unmute <= UNMUTE_RESET;
         rcom_pd_hiz <= PD_HIZ_RESET;
         rcom_power_up <= POWER_UP_RESET;
         rcom_level_reserved <= 1'b0;
      end
      else
      begin
         right_amp_to_rcom <= route_val[0][ROUTE_BIT]; // [R1]
         right_amp_to_rcom_vol <= route_val[0][VOL_LSB +: VOL_W]; // [R2] [R16]
         right_dac_primary_to_rcom <= route_val[1][ROUTE_BIT]; // [R3]
         right_dac_primary_to_rcom_vol <= route_val[1][VOL_LSB +: VOL_W]; // [R2] [R16]
         rcom_level <= level; // [R4]
         rcom_unmute <= unmute; // [R6]
         rcom_pd_hiz <= pd_hiz; // [R7]
         rcom_power_up <= power_up; // [R9]
         // Flags a reserved level code left by software
         rcom_level_reserved <= (level > LEVEL_MAX); // [R5]
      end
   end

   generate
      for (g = 0; g < 5; g++)
      begin : g_mono
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               mono_route[g] <= 1'b0;
               mono_vol[g] <= '0;
            end
            else
            begin
               mono_route[g] <= route_val[g+2][ROUTE_BIT]; // [R10] [R11] [R12] [R13] [R14]
               mono_vol[g] <= route_val[g+2][VOL_LSB +: VOL_W]; // [R15] [R16]
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_rcom_route;
      @(posedge clk) disable iff (reset)
      (reg_wr && route_sel[0]) |-> ##2 (right_amp_to_rcom == $past(reg_wdata[ROUTE_BIT], 2));
   endproperty
   a_rcom_route: assert property (p_rcom_route) else $error("right amp route not applied"); // [R1]

   property p_rcom_vol;
      @(posedge clk) disable iff (reset)
      (reg_wr && route_sel[1]) |-> ##2 (right_dac_primary_to_rcom_vol == $past(reg_wdata[6:0], 2));
   endproperty
   a_rcom_vol: assert property (p_rcom_vol) else $error("right dac volume not applied"); // [R2]

   property p_rdac_route;
      @(posedge clk) disable iff (reset)
      (reg_wr && route_sel[1]) |-> ##2 (right_dac_primary_to_rcom == $past(reg_wdata[ROUTE_BIT], 2));
   endproperty
   a_rdac_route: assert property (p_rdac_route) else $error("right dac route not applied"); // [R3]

   property p_level;
      @(posedge clk) disable iff (reset)
      (reg_wr && level_sel) |-> ##2 (rcom_level == $past(reg_wdata[7:4], 2) && rcom_unmute == $past(reg_wdata[3], 2));
   endproperty
   a_level: assert property (p_level) else $error("level or mute not applied"); // [R4]

   property p_mute_reset;
      @(posedge clk) $fell(reset) |-> (!rcom_unmute && rcom_pd_hiz && !rcom_power_up);
   endproperty
   a_mute_reset: assert property (p_mute_reset) else $error("level control reset values wrong"); // [R6]

   // Cycles since the last gain change, held once the settle time is reached
   int unsigned settle_age;

   always_ff @(posedge clk)
   begin
      if (reset)
         settle_age <= 0;
      else if (rcom_gain_change)
         settle_age <= 0;
      else if (settle_age < SETTLE)
         settle_age <= settle_age + 1;
   end

   property p_busy_after_write;
      @(posedge clk) disable iff (reset)
      (settle_age < SETTLE) |-> vol_busy;
   endproperty
   a_busy_after_write: assert property (p_busy_after_write) else $error("volume status cleared early"); // [R8]

   property p_busy_clears;
      @(posedge clk) disable iff (reset)
      (settle_age >= SETTLE) |-> !vol_busy;
   endproperty
   a_busy_clears: assert property (p_busy_clears) else $error("volume status never clears"); // [R8]

   property p_mono_route;
      @(posedge clk) disable iff (reset)
      (reg_wr && route_sel[4]) |-> ##2 (mono_route[2] == $past(reg_wdata[ROUTE_BIT], 2)
         && mono_vol[2] == $past(reg_wdata[6:0], 2));
   endproperty
   a_mono_route: assert property (p_mono_route) else $error("left dac mono route not applied"); // [R12]

   property p_mono_amp;
      @(posedge clk) disable iff (reset)
      (reg_wr && route_sel[6]) |-> ##2 (mono_route[4] == $past(reg_wdata[ROUTE_BIT], 2));
   endproperty
   a_mono_amp: assert property (p_mono_amp) else $error("right amp mono route not applied"); // [R14]

   c_level_write: cover property (@(posedge clk) disable iff (reset) reg_wr && level_sel);
   c_busy_clear: cover property (@(posedge clk) disable iff (reset) $fell(vol_busy));
   c_mono_on: cover property (@(posedge clk) disable iff (reset) mono_route == 5'h1F);
   c_busy_start: cover property (@(posedge clk) disable iff (reset) $rose(vol_busy));
   c_status_read: cover property (@(posedge clk) disable iff (reset) (reg_rd && level_sel) ##1 reg_hit);

   property p_rcom_flags;
      @(posedge clk) disable iff (reset)
      (reg_wr && level_sel) |-> ##2 (rcom_unmute == $past(reg_wdata[UNMUTE_BIT], 2)
         && rcom_pd_hiz == $past(reg_wdata[PD_HIZ_BIT], 2)
         && rcom_power_up == $past(reg_wdata[POWER_UP_BIT], 2));
   endproperty
   a_rcom_flags: assert property (p_rcom_flags) else $error("level control bits not applied"); // [R6] [R7] [R9]

   property p_rcom_amp_vol;
      @(posedge clk) disable iff (reset)
      (reg_wr && route_sel[0]) |-> ##2 (right_amp_to_rcom_vol == $past(reg_wdata[VOL_LSB +: VOL_W], 2));
   endproperty
   a_rcom_amp_vol: assert property (p_rcom_amp_vol) else $error("right amp volume not applied"); // [R2] [R16]

   property p_mono_line2_left;
      @(posedge clk) disable iff (reset)
      (reg_wr && route_sel[2]) |-> ##2 (mono_route[0] == $past(reg_wdata[ROUTE_BIT], 2)
         && mono_vol[0] == $past(reg_wdata[VOL_LSB +: VOL_W], 2));
   endproperty
   a_mono_line2_left: assert property (p_mono_line2_left) else $error("left line2 mono route not applied"); // [R10]

   property p_mono_amp_left;
      @(posedge clk) disable iff (reset)
      (reg_wr && route_sel[3]) |-> ##2 (mono_route[1] == $past(reg_wdata[ROUTE_BIT], 2)
         && mono_vol[1] == $past(reg_wdata[VOL_LSB +: VOL_W], 2));
   endproperty
   a_mono_amp_left: assert property (p_mono_amp_left) else $error("left amp mono route not applied"); // [R11]

   property p_mono_line2_right;
      @(posedge clk) disable iff (reset)
      (reg_wr && route_sel[5]) |-> ##2 (mono_route[3] == $past(reg_wdata[ROUTE_BIT], 2)
         && mono_vol[3] == $past(reg_wdata[VOL_LSB +: VOL_W], 2));
   endproperty
   a_mono_line2_right: assert property (p_mono_line2_right) else $error("right line2 mono route not applied"); // [R13]

   property p_mono_amp_vol;
      @(posedge clk) disable iff (reset)
      (reg_wr && route_sel[6]) |-> ##2 (mono_vol[4] == $past(reg_wdata[VOL_LSB +: VOL_W], 2));
   endproperty
   a_mono_amp_vol: assert property (p_mono_amp_vol) else $error("right amp mono volume not applied"); // [R15] [R16]

   property p_status_read;
      @(posedge clk) disable iff (reset)
      (reg_rd && level_sel) |=> (reg_hit && reg_rdata[VOL_BUSY_BIT] == $past(vol_busy));
   endproperty
   a_status_read: assert property (p_status_read) else $error("volume status read wrong"); // [R8]

   property p_status_readonly;
      @(posedge clk) disable iff (reset)
      (reg_wr && level_sel) |=> vol_busy;
   endproperty
   a_status_readonly: assert property (p_status_readonly) else $error("volume status not set by level write"); // [R8]

   property p_reserved_flag;
      @(posedge clk) disable iff (reset)
      rcom_level_reserved == ($past(level) > LEVEL_MAX);
   endproperty
   a_reserved_flag: assert property (p_reserved_flag) else $error("reserved level flag wrong"); // [R4] [R5]
endmodule

// ### host_model.sv
// Host model driving the register strobe port
`timescale 1ns/1ps
module host_model
   import mix_route_pkg::*;
(
   // Clock
   input wire logic clk,
   // Register port
   output logic reg_wr,
   output logic reg_rd,
   output logic [ADDR_W-1:0] reg_addr,
   output logic [DATA_W-1:0] reg_wdata,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic reg_hit
);
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 8'h00;
   end

   // Idle address and data lines show the inverse of the last value; both strobes go low
   task automatic release_bus();
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask

   task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      #1;
      if (a == ADDR_RCOM_OUT_LEVEL_CTRL && d[7:4] > LEVEL_MAX)
         d[7:4] = LEVEL_MAX;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      release_bus();
   endtask

   task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic h);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      d = reg_rdata;
      h = reg_hit;
      release_bus();
   endtask
endmodule

// ### tb.sv
// Testbench for the output mix route register bank
`timescale 1ns/1ps
module tb
   import mix_route_pkg::*;
   ;
   logic clk;
   logic reset;
   logic reg_wr;
   logic reg_rd;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic [DATA_W-1:0] reg_rdata;
   logic reg_hit;
   logic right_amp_to_rcom;
   logic [VOL_W-1:0] right_amp_to_rcom_vol;
   logic right_dac_primary_to_rcom;
   logic [VOL_W-1:0] right_dac_primary_to_rcom_vol;
   logic [LEVEL_W-1:0] rcom_level;
   logic rcom_unmute;
   logic rcom_pd_hiz;
   logic rcom_power_up;
   logic rcom_level_reserved;
   logic [4:0] mono_route;
   logic [VOL_W-1:0] mono_vol [0:4];
   logic [7:0] wr_val [0:7] = '{8'hD5, 8'h2A, 8'h9B, 8'h81, 8'h7F, 8'hC3, 8'h3C, 8'hFF};
   int fail_count = 0;
   int n_tests = 0;

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   output_mix_route_regs #(.SETTLE(4)) u_dut (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
      .right_amp_to_rcom(right_amp_to_rcom), .right_amp_to_rcom_vol(right_amp_to_rcom_vol),
      .right_dac_primary_to_rcom(right_dac_primary_to_rcom),
      .right_dac_primary_to_rcom_vol(right_dac_primary_to_rcom_vol), .rcom_level(rcom_level),
      .rcom_unmute(rcom_unmute), .rcom_pd_hiz(rcom_pd_hiz), .rcom_power_up(rcom_power_up),
      .rcom_level_reserved(rcom_level_reserved), .mono_route(mono_route), .mono_vol(mono_vol));

   host_model u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit));

   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
         fail_count++;
      end
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_reset();
      logic [7:0] d;
      logic h;
      check({right_amp_to_rcom, right_amp_to_rcom_vol}, 8'h00);
      check({right_dac_primary_to_rcom, right_dac_primary_to_rcom_vol}, 8'h00);
      check({rcom_level, rcom_unmute, rcom_pd_hiz, 1'b0, rcom_power_up}, 8'h04);
      check({3'h0, mono_route}, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         u_host.read_reg(7'(ADDR_RPGA_TO_RCOM_VOL + i), d, h);
         check({7'h00, h}, 8'h01);
         check((i == 2) ? (d & 8'hFD) : d, (i == 2) ? 8'h04 : ROUTE_RESET);
      end
   endtask

   task automatic test_write();
      logic [7:0] d;
      logic h;
      for (int i = 0; i < 8; i++)
         u_host.write_reg(7'(ADDR_RPGA_TO_RCOM_VOL + i), wr_val[i]);
      repeat (3) @(posedge clk);
      #1;
      check({right_amp_to_rcom, right_amp_to_rcom_vol}, wr_val[0]);
      check({right_dac_primary_to_rcom, right_dac_primary_to_rcom_vol}, wr_val[1]);
      check({rcom_level, rcom_unmute, rcom_pd_hiz, 1'b0, rcom_power_up}, 8'h99);
      for (int k = 0; k < 5; k++)
         check({mono_route[k], mono_vol[k]}, wr_val[k+3]);
      for (int i = 0; i < 8; i++)
      begin
         u_host.read_reg(7'(ADDR_RPGA_TO_RCOM_VOL + i), d, h);
         check((i == 2) ? (d & 8'hFD) : d, (i == 2) ? 8'h99 : wr_val[i]);
      end
   endtask

   task automatic test_level();
      logic [7:0] d;
      logic h;
      for (int lv = 0; lv < 10; lv++)
      begin
         u_host.write_reg(ADDR_RCOM_OUT_LEVEL_CTRL, {4'(lv), 4'hB});
         repeat (3) @(posedge clk);
         #1;
         check({4'h0, rcom_level}, 8'(lv));
         check({7'h00, rcom_level_reserved}, 8'h00);
      end
      u_host.write_reg(ADDR_RCOM_OUT_LEVEL_CTRL, 8'h9B);
      u_host.read_reg(ADDR_RCOM_OUT_LEVEL_CTRL, d, h);
      check(d, 8'h9B);
      repeat (20) @(posedge clk);
      u_host.read_reg(ADDR_RCOM_OUT_LEVEL_CTRL, d, h);
      check(d, 8'h99);
   endtask

   task automatic test_unmapped();
      logic [7:0] d;
      logic h;
      u_host.write_reg(7'h45, 8'h00);
      u_host.write_reg(7'h4E, 8'h00);
      u_host.read_reg(7'h4E, d, h);
      check({d[6:0], h}, 8'h00);
      u_host.read_reg(ADDR_RPGA_TO_RCOM_VOL, d, h);
      check(d, wr_val[0]);
      u_host.read_reg(ADDR_RPGA_TO_MONO_VOL, d, h);
      check(d, wr_val[7]);
   endtask

   initial
   begin
      reset = 1'b1;
      repeat (16) @(posedge clk);
      #1;
      reset = 1'b0;
      test_reset();
      test_write();
      test_unmapped();
      test_level();
      @(posedge clk);
      #1;
      reset = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      reset = 1'b0;
      test_reset();
      complete_run();
   end

   initial
   begin
      #(25 * 4000);
      fail_count++;
      complete_run();
   end
endmodule
